// [irc_pkg.sv]
// constants and types shared by both ends of the inquiry/copy command link
package irc_pkg;
   localparam logic [7:0] OP_INQUIRY     = 8'h12;
   localparam logic [7:0] OP_COPY        = 8'h18;
   localparam logic [2:0] CDB_LAST       = 3'h5;
   localparam logic [8:0] REPLY_HDR_LEN  = 9'h005;
   localparam logic [7:0] CPY_HDR_LAST   = 8'h03;
   localparam logic [8:0] MAX_DESC       = 9'h100;
   localparam logic [2:0] OTHER_PRIO     = 3'h1;
   // peripheral type codes
   localparam logic [7:0] PT_DIRECT      = 8'h00;
   localparam logic [7:0] PT_SEQUENTIAL  = 8'h01;
   localparam logic [7:0] PT_PRINTER     = 8'h02;
   localparam logic [7:0] PT_PROCESSOR   = 8'h03;
   localparam logic [7:0] PT_WORM        = 8'h04;
   localparam logic [7:0] PT_RO_DIRECT   = 8'h05;
   localparam logic [7:0] PT_ABSENT      = 8'h7F;
   localparam logic [7:0] PT_VENDOR_BASE = 8'h80;
   // national version codes
   localparam logic [2:0] VER_UNSPEC     = 3'h0;
   localparam logic [2:0] VER_THIS       = 3'h1;
   // copy function codes and their descriptor lengths in bytes
   localparam logic [4:0] FN_DA_TO_SEQ   = 5'h00;
   localparam logic [4:0] FN_SEQ_TO_DA   = 5'h01;
   localparam logic [4:0] FN_DA_TO_DA    = 5'h02;
   localparam logic [4:0] FN_SEQ_TO_SEQ  = 5'h03;
   localparam logic [7:0] DESC_LEN_MIXED = 8'h0C;
   localparam logic [7:0] DESC_LEN_DA    = 8'h10;
   localparam logic [7:0] DESC_LEN_SEQ   = 8'h0C;
   // reply and parameter field positions
   localparam int RMB_BIT  = 7;
   localparam int ISO_LSB  = 6;
   localparam int ECMA_LSB = 3;
   localparam int FN_LSB   = 3;
   typedef enum logic [1:0] {IRC_INQUIRY, IRC_COPY, IRC_RAW} irc_op_t;
endpackage : irc_pkg

// [irc_link_if.sv]
// byte link between the initiator end and the target end
`timescale 1ns/1ps
`default_nettype none
interface irc_link_if (
   input wire logic clk
);
   logic       h2d_valid;
   logic [7:0] h2d_data;
   logic       h2d_ready;
   logic       d2h_valid;
   logic [7:0] d2h_data;
   logic       d2h_ready;
   logic       status_valid;
   logic       status_check;
   modport dev  (input h2d_valid, h2d_data, d2h_ready,
                 output h2d_ready, d2h_valid, d2h_data, status_valid, status_check);
   modport host (output h2d_valid, h2d_data, d2h_ready,
                 input h2d_ready, d2h_valid, d2h_data, status_valid, status_check);
endinterface : irc_link_if
`default_nettype wire

// [irc_host.sv]
// initiator end: sends command blocks, parameter bytes, takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module irc_host
   import irc_pkg::*;
(
   input  wire logic       clk,          // system clock
   input  wire logic       rst,          // synchronous reset
   irc_link_if.host        link,         // link to the target
   input  wire logic       req_valid,    // start a command
   input  wire irc_op_t    req_op,       // command kind
   input  wire logic [23:0] req_len,     // allocation or parameter length
   input  wire logic [2:0] req_lun,      // logical unit number
   output logic            req_ready,    // idle, request accepted
   input  wire logic       wr_valid,     // parameter byte offered
   input  wire logic [7:0] wr_data,      // parameter byte
   output logic            wr_ready,     // parameter byte taken
   output logic            rd_valid,     // reply byte pulse
   output logic [7:0]      rd_data,      // reply byte
   output logic            done,         // command ended pulse
   output logic            done_check    // command ended with check condition
);
   typedef enum logic [1:0] {H_IDLE, H_CDB, H_DOUT, H_WAIT} irc_hst_t;
   typedef struct packed {
      irc_hst_t    st;
      logic [5:0][7:0] cdb;
      logic [2:0]  ci;
      logic [23:0] left;
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic        rd_valid;
      logic [7:0]  rd_data;
      logic        done;
      logic        chk;
   } irc_hstate_t;

   irc_hstate_t s_reg, s_next;
   logic        tx_free;

   assign tx_free         = !s_reg.tx_valid || link.h2d_ready;
   assign link.h2d_valid  = s_reg.tx_valid;
   assign link.h2d_data   = s_reg.tx_data;
   assign link.d2h_ready  = 1'b1;
   assign req_ready       = (s_reg.st == H_IDLE);
   assign wr_ready        = (s_reg.st == H_DOUT) && tx_free && (s_reg.left != 24'h000000);
   assign rd_valid        = s_reg.rd_valid;
   assign rd_data         = s_reg.rd_data;
   assign done            = s_reg.done;
   assign done_check      = s_reg.chk;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next          = s_reg;
      s_next.done     = 1'b0;
      s_next.rd_valid = link.d2h_valid;
      if (link.d2h_valid) begin
         s_next.rd_data = link.d2h_data;
      end
      if (tx_free) begin
         s_next.tx_valid = 1'b0;
      end
      case (s_reg.st)
         H_IDLE: begin
            if (req_valid) begin
               s_next.ci   = 3'h0;
               s_next.left = (req_op == IRC_COPY) ? req_len : 24'h000000;
               s_next.cdb[0] = (req_op == IRC_COPY) ? OP_COPY :
                               (req_op == IRC_INQUIRY) ? OP_INQUIRY : req_len[7:0];
               s_next.cdb[1] = {req_lun, 5'h00};
               s_next.cdb[2] = (req_op == IRC_COPY) ? req_len[23:16] : 8'h00; // RULE9
               s_next.cdb[3] = (req_op == IRC_COPY) ? req_len[15:8] : 8'h00;
               s_next.cdb[4] = req_len[7:0];
               s_next.cdb[5] = 8'h00;
               s_next.st     = H_CDB;
            end
         end
         H_CDB: begin
            if (tx_free) begin
               s_next.tx_valid = 1'b1;
               s_next.tx_data  = s_reg.cdb[s_reg.ci];
               s_next.ci       = s_reg.ci + 3'h1;
               if (s_reg.ci == CDB_LAST) begin
                  s_next.st = (s_reg.left == 24'h000000) ? H_WAIT : H_DOUT; // RULE10
               end
            end
         end
         H_DOUT: begin
            if (wr_valid && wr_ready) begin
               s_next.tx_valid = 1'b1;
               s_next.tx_data  = wr_data;
               s_next.left     = s_reg.left - 24'h000001; // RULE10
               if (s_reg.left == 24'h000001) begin
                  s_next.st = H_WAIT;
               end
            end
         end
         H_WAIT: begin
            if (link.status_valid) begin
               s_next.done = 1'b1;
               s_next.chk  = link.status_check;
               s_next.st   = H_IDLE;
            end
         end
         default: s_next.st = H_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : irc_host
`default_nettype wire

// [irc_target.sv]
// target end: inquiry reply builder and copy command/parameter parser
//
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: reply byte 0 is the peripheral type
// RULE2: byte 1 top bit is removable medium flag
// RULE3: byte 1 low bits qualifier, zero if unsupported
// RULE4: byte 2 holds international, European, national versions
// RULE5: national version only 0 or 1
// RULE6: byte 4 counts vendor bytes that follow
// RULE7: byte 4 never shortened by small allocation
// RULE8: send min of allocation and available bytes
// RULE9: copy opcode 18h, 24-bit length, MSB first
// RULE10: exactly length bytes out; zero means none
// RULE11: four-byte header: function, priority, vendor, reserved
// RULE12: priority ranks copy; other commands are one
// RULE13: worm and read-only use direct-access format
// RULE14: printer and processor use sequential format
// RULE15: at most 256 segment descriptors
// RULE16: descriptors numbered ascending from zero
// RULE17: only copies between own logical units; the descriptor logical unit fields are not checked
// RULE18: too many descriptors or bad function: check
module irc_target
   import irc_pkg::*;
(
   input  wire logic       clk,          // system clock
   input  wire logic       rst,          // synchronous reset
   irc_link_if.dev         link,         // link to the initiator
   input  wire logic [7:0] cfg_type,     // peripheral type code
   input  wire logic       cfg_removable,// medium can be removed
   input  wire logic       cfg_qual_en,  // qualifier switches fitted
   input  wire logic [6:0] cfg_qual,     // qualifier switch setting
   input  wire logic [1:0] cfg_iso_ver,  // international version claim
   input  wire logic [2:0] cfg_ecma_ver, // European version claim
   input  wire logic       cfg_compliant,// claim this national version
   input  wire logic [7:0] vend_len,     // count of vendor bytes
   output logic [7:0]      vend_addr,    // vendor byte index
   input  wire logic [7:0] vend_data,    // vendor byte at vend_addr
   output logic            copy_hdr,     // copy header parsed pulse
   output logic [4:0]      copy_func,    // copy function code
   output logic [2:0]      copy_prio,    // copy priority
   output logic            copy_first,   // copy outranks other commands
   output logic            copy_last,    // other commands outrank copy
   output logic            desc_done,    // one descriptor received pulse
   output logic [7:0]      desc_index,   // number of that descriptor
   output logic [7:0]      desc_len,     // descriptor length of this format
   output logic            cmd_done,     // status sent pulse
   output logic            cmd_check     // status was check condition
);
   typedef enum logic [2:0] {T_CDB, T_DECODE, T_DIN, T_DOUT, T_STATUS} irc_tst_t;
   typedef struct packed {
      irc_tst_t    st;
      logic [5:0][7:0] cdb;
      logic [23:0] idx;
      logic [23:0] limit;
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic [4:0]  func;
      logic [2:0]  prio;
      logic [7:0]  dlen;
      logic [7:0]  dbyte;
      logic [8:0]  dcnt;
      logic        hdr;
      logic        ddone;
      logic [7:0]  did;
      logic        err;
      logic        stat;
   } irc_tstate_t;

   irc_tstate_t s_reg, s_next;
   logic [8:0]  avail;
   logic [7:0]  reply;
   logic        tx_free;

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign tx_free           = !s_reg.tx_valid || link.d2h_ready;
   assign link.h2d_ready    = (s_reg.st == T_CDB) || (s_reg.st == T_DOUT);
   assign link.d2h_valid    = s_reg.tx_valid;
   assign link.d2h_data     = s_reg.tx_data;
   assign link.status_valid = s_reg.stat;
   assign link.status_check = s_reg.err;
   assign cmd_done          = s_reg.stat;
   assign cmd_check         = s_reg.err;
   assign copy_hdr          = s_reg.hdr;
   assign copy_func         = s_reg.func;
   assign copy_prio         = s_reg.prio;
   assign copy_first        = (s_reg.prio < OTHER_PRIO); // RULE12
   assign copy_last         = (s_reg.prio > OTHER_PRIO); // RULE12
   assign desc_done         = s_reg.ddone;
   assign desc_index        = s_reg.did;
   assign desc_len          = s_reg.dlen;
   assign vend_addr         = s_reg.idx[7:0] - REPLY_HDR_LEN[7:0];
   assign avail             = REPLY_HDR_LEN + {1'b0, vend_len};

   ////////////////////////////////////////////////////////////////////////////
   // inquiry reply byte at the current index
   always_comb begin
      case (s_reg.idx[2:0])
         3'h0: reply = cfg_type; // RULE1
         3'h1: reply = {cfg_removable, cfg_qual_en ? cfg_qual : 7'h00}; // RULE2 RULE3
         3'h2: reply = {cfg_iso_ver, cfg_ecma_ver,
                        cfg_compliant ? VER_THIS : VER_UNSPEC}; // RULE4 RULE5
         3'h3: reply = 8'h00;
         3'h4: reply = vend_len; // RULE6 RULE7
         default: reply = vend_data;
      endcase
      if (s_reg.idx >= {15'h0000, REPLY_HDR_LEN}) begin
         reply = vend_data; // RULE6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command sequencer
   always_comb begin
      s_next       = s_reg;
      s_next.hdr   = 1'b0;
      s_next.ddone = 1'b0;
      s_next.stat  = 1'b0;
      if (tx_free) begin
         s_next.tx_valid = 1'b0;
      end
      case (s_reg.st)
         T_CDB: begin
            if (link.h2d_valid) begin
               s_next.cdb[s_reg.idx[2:0]] = link.h2d_data;
               s_next.idx = s_reg.idx + 24'h000001;
               if (s_reg.idx[2:0] == CDB_LAST) begin
                  s_next.st = T_DECODE;
               end
            end
         end
         T_DECODE: begin
            s_next.idx   = 24'h000000;
            s_next.dbyte = 8'h00;
            s_next.dcnt  = 9'h000;
            if (s_reg.cdb[0] == OP_INQUIRY) begin
               // RULE8
               s_next.limit = ({1'b0, s_reg.cdb[4]} < avail) ? {16'h0000, s_reg.cdb[4]}
                                                             : {15'h0000, avail};
               s_next.st    = (s_reg.cdb[4] == 8'h00) ? T_STATUS : T_DIN;
            end else if (s_reg.cdb[0] == OP_COPY) begin
               s_next.limit = {s_reg.cdb[2], s_reg.cdb[3], s_reg.cdb[4]}; // RULE9
               s_next.st    = ({s_reg.cdb[2], s_reg.cdb[3], s_reg.cdb[4]} == 24'h000000)
                              ? T_STATUS : T_DOUT; // RULE10
            end else begin
               s_next.err = 1'b1;
               s_next.st  = T_STATUS;
            end
         end
         T_DIN: begin
            if (tx_free) begin
               if (s_reg.idx != s_reg.limit) begin
                  s_next.tx_valid = 1'b1;
                  s_next.tx_data  = reply;
                  s_next.idx      = s_reg.idx + 24'h000001;
               end else begin
                  s_next.st = T_STATUS; // RULE8
               end
            end
         end
         T_DOUT: begin
            if (link.h2d_valid) begin
               s_next.idx = s_reg.idx + 24'h000001;
               if (s_reg.idx == 24'h000000) begin
                  s_next.func = link.h2d_data[7:FN_LSB]; // RULE11
                  s_next.prio = link.h2d_data[FN_LSB-1:0]; // RULE11 RULE12
               end else if (s_reg.idx == {16'h0000, CPY_HDR_LAST}) begin
                  s_next.hdr = 1'b1;
                  // worm and read-only units share the direct-access layout,
                  // printer and processor share the sequential layout
                  case (s_reg.func)
                     FN_DA_TO_SEQ:  s_next.dlen = DESC_LEN_MIXED; // RULE13 RULE14
                     FN_SEQ_TO_DA:  s_next.dlen = DESC_LEN_MIXED; // RULE13 RULE14
                     FN_DA_TO_DA:   s_next.dlen = DESC_LEN_DA; // RULE13
                     FN_SEQ_TO_SEQ: s_next.dlen = DESC_LEN_SEQ; // RULE14
                     default: begin
                        s_next.dlen = DESC_LEN_DA;
                        s_next.err  = 1'b1; // RULE18
                     end
                  endcase
               end else if (s_reg.idx > {16'h0000, CPY_HDR_LAST}) begin
                  // descriptor bytes are only counted here; their logical unit fields are not checked
                  s_next.dbyte = s_reg.dbyte + 8'h01; // RULE17
                  if (s_reg.dbyte == s_reg.dlen - 8'h01) begin
                     s_next.dbyte = 8'h00;
                     s_next.dcnt  = s_reg.dcnt + 9'h001; // RULE16
                     if (s_reg.dcnt == MAX_DESC) begin
                        s_next.err = 1'b1; // RULE15 RULE18
                     end else begin
                        s_next.ddone = 1'b1;
                        s_next.did   = s_reg.dcnt[7:0]; // RULE16
                     end
                  end
               end
               if (s_reg.idx == s_reg.limit - 24'h000001) begin
                  s_next.st = T_STATUS; // RULE10
                  // short header, partial or missing descriptor
                  if (s_reg.idx <= {16'h0000, CPY_HDR_LAST} ||
                      s_reg.dbyte != s_reg.dlen - 8'h01) begin
                     s_next.err = 1'b1; // RULE11
                  end
               end
            end
         end
         T_STATUS: begin
            s_next.stat = 1'b1;
            s_next.idx  = 24'h000000;
            s_next.st   = T_CDB;
         end
         default: s_next.st = T_CDB;
      endcase
      if (s_reg.stat) begin
         s_next.err = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : irc_target
`default_nettype wire

// [irc_link_checker.sv]
// concurrent checks on the byte link between the initiator and target ends
`timescale 1ns/1ps
`default_nettype none
module irc_link_checker (
   input wire logic       clk,          // system clock
   input wire logic       rst,          // synchronous reset
   input wire logic       h2d_valid,    // host byte valid
   input wire logic [7:0] h2d_data,     // host byte
   input wire logic       h2d_ready,    // target takes host byte
   input wire logic       d2h_valid,    // reply byte valid
   input wire logic [7:0] d2h_data,     // reply byte
   input wire logic       d2h_ready,    // host takes reply byte
   input wire logic       status_valid, // status pulse
   input wire logic       status_check  // check condition with status
);
   logic [8:0] rcnt_reg;
   logic [3:0] hcnt_reg;
   ////////////////////////////////////////////////////////////////////////////
   // beats of each command, cleared by its status
   always_ff @(posedge clk) begin
      if (rst || status_valid) begin
         rcnt_reg <= 9'h000;
         hcnt_reg <= 4'h0;
      end else begin
         if (d2h_valid && d2h_ready) begin
            rcnt_reg <= rcnt_reg + 9'h001;
         end
         if (h2d_valid && h2d_ready && hcnt_reg != 4'hF) begin
            hcnt_reg <= hcnt_reg + 4'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   after_reset_a: assert property ($fell(rst) |-> h2d_ready && !d2h_valid && !status_valid)
      else $error("link not idle after reset");
   status_pulse_a: assert property (status_valid |=> !status_valid)
      else $error("status longer than one cycle");
   reply_excl_a: assert property (d2h_valid |-> !h2d_ready && !status_valid)
      else $error("reply byte overlaps intake or status");
   hold_byte_a: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
      else $error("host byte dropped before taken");
   reply_end_a: assert property ($fell(d2h_valid) |=> status_valid)
      else $error("status not one cycle after last reply byte");
   reserved_byte_a: assert property (d2h_valid && rcnt_reg == 9'h003 |-> d2h_data == 8'h00)
      else $error("reply byte 3 not zero");
   national_ver_a: assert property (d2h_valid && rcnt_reg == 9'h002 |-> d2h_data[2:0] <= 3'h1)
      else $error("national version code reserved");
   cdb_first_a: assert property (status_valid |-> hcnt_reg >= 4'h6)
      else $error("status before six command bytes");
   back_to_cdb_a: assert property (status_valid |-> h2d_ready)
      else $error("target not collecting after status");
   inquiry_good_a: assert property ($fell(d2h_valid) |=> !status_check)
      else $error("reply ended with check condition");
endmodule : irc_link_checker
`default_nettype wire

// [inquiry_reply_copy_parser_bench.sv]
// self-checking bench: host end and target end joined over the link
`timescale 1ns/1ps
`default_nettype none
module inquiry_reply_copy_parser_bench
   import irc_pkg::*;
;
   logic        clk, rst, req_valid, req_ready, wr_valid, wr_ready, rd_valid, done, done_check;
   logic        cfg_removable, cfg_qual_en, cfg_compliant, copy_hdr, copy_first, copy_last;
   logic        desc_done, cmd_done, cmd_check, last_chk, last_tchk;
   irc_op_t     req_op;
   logic [23:0] req_len;
   logic [7:0]  wr_data, rd_data, cfg_type, vend_len, vend_addr, vend_data, desc_index, desc_len;
   logic [7:0]  exp_dl;
   logic [6:0]  cfg_qual;
   logic [4:0]  copy_func;
   logic [2:0]  cfg_ecma_ver, copy_prio;
   logic [1:0]  cfg_iso_ver;
   int          err_total, n_tests, ndesc, nhdr, ndone, t, i;
   logic [7:0]  rep [$];
   logic [7:0]  par [0:4095];
   logic [7:0]  types [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h7F, 8'h80, 8'hFF};
   irc_link_if irc_link_if_inst (.clk(clk));
   irc_host irc_host_inst (.clk(clk), .rst(rst), .link(irc_link_if_inst), .req_valid(req_valid),
      .req_op(req_op), .req_len(req_len), .req_lun(3'h0), .req_ready(req_ready),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
      .rd_data(rd_data), .done(done), .done_check(done_check));
   irc_target irc_target_inst (.clk(clk), .rst(rst), .link(irc_link_if_inst),
      .cfg_type(cfg_type), .cfg_removable(cfg_removable), .cfg_qual_en(cfg_qual_en),
      .cfg_qual(cfg_qual), .cfg_iso_ver(cfg_iso_ver), .cfg_ecma_ver(cfg_ecma_ver),
      .cfg_compliant(cfg_compliant), .vend_len(vend_len), .vend_addr(vend_addr),
      .vend_data(vend_data), .copy_hdr(copy_hdr), .copy_func(copy_func), .copy_prio(copy_prio),
      .copy_first(copy_first), .copy_last(copy_last), .desc_done(desc_done),
      .desc_index(desc_index), .desc_len(desc_len), .cmd_done(cmd_done), .cmd_check(cmd_check));
   irc_link_checker irc_link_checker_inst (.clk(clk), .rst(rst),
      .h2d_valid(irc_link_if_inst.h2d_valid), .h2d_data(irc_link_if_inst.h2d_data),
      .h2d_ready(irc_link_if_inst.h2d_ready), .d2h_valid(irc_link_if_inst.d2h_valid),
      .d2h_data(irc_link_if_inst.d2h_data), .d2h_ready(irc_link_if_inst.d2h_ready),
      .status_valid(irc_link_if_inst.status_valid),
      .status_check(irc_link_if_inst.status_check));
   // vendor bytes are a pattern of their index
   assign vend_data = vend_addr ^ 8'h5A;
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rd_valid) rep.push_back(rd_data);
      if (done) begin
         ndone++;
         last_chk = done_check;
      end
      if (cmd_done) last_tchk = cmd_check;
      if (copy_hdr) nhdr++;
      if (desc_done) begin
         if (ndesc < 256) check(32'(desc_index), ndesc);
         check(32'(desc_len), 32'(exp_dl));
         ndesc++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   // waits for req_ready (sel 0) or wr_ready (sel 1), then passes the taking edge
   task automatic hs(input bit sel);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while ((sel ? wr_ready : req_ready) !== 1'b1 && k < 5000);
      if (k >= 5000) begin
         err_total++;
         summarize();
      end
      @(posedge clk);
   endtask : hs
   task automatic run(input irc_op_t op, input logic [23:0] len, input int np, input logic chk);
      int k, d0;
      rep.delete();
      ndesc = 0;
      nhdr = 0;
      d0 = ndone;
      @(posedge clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_len <= len;
      hs(1'b0);
      req_valid <= 1'b0;
      for (k = 0; k < np; k++) begin
         wr_valid <= 1'b1;
         wr_data <= par[k];
         hs(1'b1);
      end
      wr_valid <= 1'b0;
      k = 0;
      while (ndone == d0 && k < 5000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 5000) begin
         err_total++;
         summarize();
      end
      check(32'(last_chk), 32'(chk));
      check(32'(last_tchk), 32'(chk));
      $display("command %0h ended, checks so far %0d", op, n_tests);
   endtask : run
   // fl: removable, qualifier fitted, compliant; ver: international and European claims
   task automatic inq(input logic [7:0] ty, input logic [2:0] fl, input logic [6:0] q,
                      input logic [4:0] ver, input logic [7:0] vl, input logic [7:0] al);
      logic [7:0] e [$];
      int j, n;
      cfg_type <= ty;
      {cfg_removable, cfg_qual_en, cfg_compliant} <= fl;
      cfg_qual <= q;
      {cfg_iso_ver, cfg_ecma_ver} <= ver;
      vend_len <= vl;
      e = '{ty, {fl[2], fl[1] ? q : 7'h00}, {ver, 2'b00, fl[0]}, 8'h00, vl};
      for (j = 0; j < vl; j++) e.push_back(j[7:0] ^ 8'h5A);
      run(IRC_INQUIRY, {16'h0000, al}, 0, 1'b0);
      n = (al < e.size()) ? al : e.size();
      check(rep.size(), n);
      for (j = 0; j < n && j < rep.size(); j++) begin
         check(32'(rep[j]), 32'(e[j]));
      end
   endtask : inq
   task automatic cpy(input logic [4:0] fn, input logic [2:0] pr, input int nd, input int extra,
                      input logic chk);
      int j, len;
      exp_dl = (fn == FN_DA_TO_DA) ? DESC_LEN_DA :
               (fn == FN_SEQ_TO_SEQ) ? DESC_LEN_SEQ : DESC_LEN_MIXED;
      len = (nd == 0 && extra == 0) ? 0 : 4 + nd * exp_dl + extra;
      par[0] = {fn, pr};
      par[1] = 8'hA5;
      par[2] = 8'h00;
      par[3] = 8'h00;
      for (j = 4; j < len; j++) par[j] = j[7:0];
      run(IRC_COPY, len[23:0], len, chk);
      if (len != 0) begin
         check(32'(copy_func), 32'(fn));
         check(32'(copy_prio), 32'(pr));
         check(32'(copy_first), 32'(pr < OTHER_PRIO));
         check(32'(copy_last), 32'(pr > OTHER_PRIO));
      end
      if (!chk) begin
         check(ndesc, nd);
         check(nhdr, 32'(len != 0));
      end
   endtask : cpy
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, req_valid, wr_valid, cfg_removable, cfg_qual_en, cfg_compliant} = 6'b100000;
      {req_len, wr_data, cfg_type, vend_len, cfg_qual} = '0;
      {cfg_iso_ver, cfg_ecma_ver, last_chk, last_tchk} = '0;
      req_op = IRC_INQUIRY;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      inq(PT_DIRECT, 3'b111, 7'h55, 5'b10011, 8'h03, 8'h08);
      inq(PT_ABSENT, 3'b000, 7'h7F, 5'h00, 8'h0A, 8'h06);
      inq(PT_SEQUENTIAL, 3'b010, 7'h01, 5'h07, 8'h02, 8'h00);
      inq(PT_WORM, 3'b100, 7'h33, 5'h10, 8'h04, 8'hFF);
      for (t = 0; t < 9; t++) inq(types[t], 3'b101, 7'h2A, 5'h08, 8'h00, 8'h02);
      for (i = 0; i < 4; i++) cpy(i[4:0], 3'(i * 3 - i / 2), i + 1, 0, 1'b0);
      cpy(FN_DA_TO_SEQ, 3'h0, 0, 0, 1'b0);
      cpy(5'h05, 3'h1, 1, 0, 1'b1);
      cpy(FN_DA_TO_DA, 3'h1, 1, 5, 1'b1);
      cpy(FN_SEQ_TO_SEQ, 3'h2, 256, 0, 1'b0);
      cpy(FN_SEQ_TO_SEQ, 3'h2, 257, 0, 1'b1);
      run(IRC_RAW, 24'h0000C1, 0, 1'b1);
      summarize();
   end
endmodule : inquiry_reply_copy_parser_bench
`default_nettype wire
